// [inc/prt_if.sv]
`timescale 1ns/1ps
interface prt_if;
  logic       cs0_n;
  logic       cs1_n;
  logic [2:0] da;
  logic       dior_n;
  logic       diow_n;
  logic       dmack_n;
  logic [7:0] dd_h_out;
  logic       dd_h_oe;
  logic [7:0] dd_d_out;
  logic       dd_d_oe;
  logic       iordy_d_out;
  logic       iordy_d_oe;
  logic [7:0] dd;
  logic       iordy;

  // ==========================================================
  // wire resolution: released lines float to the pulled-up level
  assign dd    = dd_h_oe ? dd_h_out
               : (dd_d_oe ? dd_d_out : prt_pkg::BUS_IDLE);
  assign iordy = iordy_d_oe ? iordy_d_out : 1'b1;

  modport host_mp (
    output cs0_n, cs1_n, da, dior_n, diow_n, dmack_n,
    output dd_h_out, dd_h_oe,
    input  dd, iordy
  );

  modport dev_mp (
    input  cs0_n, cs1_n, da, dior_n, diow_n, dmack_n,
    input  dd,
    output dd_d_out, dd_d_oe, iordy_d_out, iordy_d_oe
  );
endinterface

// [inc/prt_pkg.sv]
package prt_pkg;

  // ==========================================================
  // clock and mode timing
  localparam int CLK_NS = 100;
  localparam int MODES  = 5;
  typedef int prt_tab_type [MODES];

  localparam prt_tab_type T0_NS  = '{600, 383, 330, 180, 120};
  localparam prt_tab_type T1_NS  = '{70, 50, 30, 30, 25};
  localparam prt_tab_type T2_NS  = '{290, 290, 290, 80, 70};
  localparam prt_tab_type T2I_NS = '{0, 0, 0, 70, 25};
  localparam prt_tab_type T9_NS  = '{20, 15, 10, 10, 10};
  localparam int TA_NS = 35;
  localparam int TB_NS = 1250;

  // least times round up, longest times round down, never below one
  function automatic int ceil_cyc(input int ns);
    int r;
    r = (ns + CLK_NS - 1) / CLK_NS;
    return (r < 1) ? 1 : r;
  endfunction

  function automatic int floor_cyc(input int ns);
    int r;
    r = ns / CLK_NS;
    return (r < 1) ? 1 : r;
  endfunction

  localparam int CNT_W  = 8;
  localparam int TA_CYC = ceil_cyc(TA_NS);
  localparam int TB_CYC = floor_cyc(TB_NS);

  function automatic logic [CNT_W-1:0] mode_cyc(input prt_tab_type tab,
                                                input logic [2:0] m);
    logic [2:0] i;
    i = (m > 3'h4) ? 3'h4 : m;
    return CNT_W'(ceil_cyc(tab[i]));
  endfunction

  // ==========================================================
  // modes
  localparam logic [2:0] PWRUP_MODE = 3'h0;
  localparam logic [2:0] SLOW_LIMIT = 3'h2;
  localparam logic [2:0] IORDY_MODE = 3'h3;
  localparam logic [2:0] TOP_MODE   = 3'h4;
  localparam logic [7:0] BUS_IDLE   = 8'hFF;

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_STROBE, H_WAIT, H_HOLD, H_RECOV
  } prt_hstate_type;

endpackage

// [logic/prt_device.sv]
`timescale 1ns/1ps
module prt_device #(
  parameter int MAX_MODE = 4,
  parameter int CYCLE_NS = 120
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  prt_if.dev_mp           bus,
  input  wire logic       mode_wr,
  input  wire logic [2:0] mode_wr_val,
  input  wire logic [7:0] rd_data,
  input  wire logic       ready,
  output logic            acc_cs_sel,
  output logic      [2:0] acc_da,
  output logic            wr_pulse,
  output logic      [7:0] wr_data,
  output logic            rd_pulse,
  output logic      [2:0] mode_cur,
  output logic     [15:0] word68,
  output logic            mode_reject,
  output logic            wait_timeout
);
  initial begin
    if (MAX_MODE < 0 || MAX_MODE > 4) $error("prt_device: bad MAX_MODE");
    if (MAX_MODE >= 3 && CYCLE_NS < prt_pkg::T0_NS[MAX_MODE])
      $error("prt_device: CYCLE_NS below mode minimum");
    if (prt_pkg::PWRUP_MODE > prt_pkg::SLOW_LIMIT)
      $error("prt_device: power-up mode too fast");
  end

  // ==========================================================
  // pin decode
  // a register is selected by exactly one chip select with the dma
  // acknowledge negated; both selects low is not a register address
  wire sel    = (bus.cs0_n ^ bus.cs1_n) & bus.dmack_n;
  wire rd_act = sel & ~bus.dior_n;
  wire wr_act = sel & ~bus.diow_n;
  wire wait_en = mode_cur >= prt_pkg::IORDY_MODE;

  logic rd_q_reg;
  logic wr_q_reg;
  logic ready_q_reg;
  logic neg_reg;
  logic dd_oe_reg;
  logic [7:0] dd_out_reg;
  logic [prt_pkg::CNT_W-1:0] wcnt;
  logic                      wmax;

  // edges are taken from the sampled strobes alone, so any host split
  // of assertion and recovery that meets the minima is served
  wire rd_start = rd_act & ~rd_q_reg;
  wire wr_start = wr_act & ~wr_q_reg;
  wire wr_end   = wr_q_reg & bus.diow_n;
  wire rd_end   = rd_q_reg & bus.dior_n;
  wire strobing = rd_act | wr_act;

  // data leads the release of the wait by one cycle: dd_out loads at
  // the edge ready is first seen, the release follows a cycle later
  wire rel_ok  = ready & ready_q_reg;
  wire tmo     = neg_reg & strobing & wmax;
  // a new wait only starts outside a strobe: the host looks once, so a
  // negation after the release would only glitch the line
  wire neg_next = wait_en & ~rel_ok & ~tmo
                & (neg_reg | ~strobing);
  wire mode_ok = mode_wr_val <= 3'(MAX_MODE);

  prt_timer #(.W(prt_pkg::CNT_W)) u_wait (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (~(neg_reg & strobing)),
    .limit   (prt_pkg::CNT_W'(prt_pkg::TB_CYC)),
    .count   (wcnt),
    .reached (wmax)
  );

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_q_reg     <= 1'b0;
      wr_q_reg     <= 1'b0;
      ready_q_reg  <= 1'b0;
      neg_reg      <= 1'b0;
      dd_oe_reg    <= 1'b0;
      dd_out_reg   <= 8'h00;
      acc_cs_sel   <= 1'b0;
      acc_da       <= 3'h0;
      wr_pulse     <= 1'b0;
      wr_data      <= 8'h00;
      rd_pulse     <= 1'b0;
      mode_cur     <= prt_pkg::PWRUP_MODE;
      word68       <= 16'h0000;
      mode_reject  <= 1'b0;
      wait_timeout <= 1'b0;
    end else begin
      rd_q_reg     <= rd_act;
      wr_q_reg     <= wr_act;
      ready_q_reg  <= ready;
      neg_reg      <= neg_next;
      dd_oe_reg    <= rd_act;
      dd_out_reg   <= rd_data;
      wr_pulse     <= wr_end;
      rd_pulse     <= rd_end;
      mode_reject  <= mode_wr & ~mode_ok;
      wait_timeout <= tmo;
      word68       <= (MAX_MODE >= 3) ? 16'(CYCLE_NS) : 16'h0000;
      if (rd_start | wr_start) begin
        acc_cs_sel <= bus.cs0_n;
        acc_da     <= bus.da;
      end
      if (wr_end) begin
        wr_data <= bus.dd;
      end
      if (mode_wr & mode_ok) begin
        mode_cur <= mode_wr_val;
      end
    end
  end

  assign bus.dd_d_out    = dd_out_reg;
  assign bus.dd_d_oe     = dd_oe_reg;
  assign bus.iordy_d_out = 1'b0;
  assign bus.iordy_d_oe  = neg_reg;
endmodule

// [logic/prt_host.sv]
`timescale 1ns/1ps
module prt_host (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  prt_if.host_mp          bus,
  input  wire logic       req,
  input  wire logic       req_wr,
  input  wire logic       req_cs_sel,
  input  wire logic [2:0] req_da,
  input  wire logic [7:0] req_wdata,
  input  wire logic [2:0] mode_req,
  input  wire logic [2:0] dev0_mode,
  input  wire logic [2:0] dev1_mode,
  input  wire logic       dev1_present,
  input  wire logic       iordy_always,
  output logic            busy,
  output logic            done,
  output logic      [7:0] rdata,
  output logic      [2:0] mode_used,
  output logic            waited
);

  // ==========================================================
  // mode choice
  function automatic logic [2:0] min3(input logic [2:0] a,
                                      input logic [2:0] b);
    return (a < b) ? a : b;
  endfunction

  // with a second device on the cable the slower one bounds the mode
  wire [2:0] slow_dev  = dev1_present ? min3(dev0_mode, dev1_mode)
                                      : dev0_mode;
  wire [2:0] mode_next = min3(min3(mode_req, slow_dev),
                              prt_pkg::TOP_MODE);

  // ==========================================================
  // state and latched request
  prt_pkg::prt_hstate_type state_reg;
  prt_pkg::prt_hstate_type state_next;
  logic       wr_reg;
  logic       cs_sel_reg;
  logic [2:0] da_reg;
  logic [7:0] wdata_reg;
  logic [2:0] mode_reg;
  logic       use_iordy_reg;
  logic       cs0_n_reg;
  logic       cs1_n_reg;
  logic       dior_n_reg;
  logic       diow_n_reg;
  logic       dd_oe_reg;
  logic       dmack_n_reg;

  // ==========================================================
  // cycle counts for the latched mode
  // every minimum is rounded up so a slow clock never shortens a phase
  wire [prt_pkg::CNT_W-1:0] t0_cyc =
    prt_pkg::mode_cyc(prt_pkg::T0_NS, mode_reg);
  wire [prt_pkg::CNT_W-1:0] t1_cyc =
    prt_pkg::mode_cyc(prt_pkg::T1_NS, mode_reg);
  wire [prt_pkg::CNT_W-1:0] t2_cyc =
    prt_pkg::mode_cyc(prt_pkg::T2_NS, mode_reg);
  wire [prt_pkg::CNT_W-1:0] t2i_cyc =
    prt_pkg::mode_cyc(prt_pkg::T2I_NS, mode_reg);
  wire [prt_pkg::CNT_W-1:0] t9_cyc =
    prt_pkg::mode_cyc(prt_pkg::T9_NS, mode_reg);

  // ==========================================================
  // timers
  // phase: cycles since the current phase began; recovery runs on
  // from the strobe negation across hold and recovery states
  // total: cycles since the strobe was asserted
  logic [prt_pkg::CNT_W-1:0] ph_cnt;
  logic [prt_pkg::CNT_W-1:0] tot_cnt;
  logic                      ph_clr;
  logic                      tot_clr;

  prt_timer #(.W(prt_pkg::CNT_W)) u_phase (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (ph_clr),
    .limit   (prt_pkg::CNT_W'(1)),
    .count   (ph_cnt),
    .reached ()
  );

  prt_timer #(.W(prt_pkg::CNT_W)) u_total (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (tot_clr),
    .limit   (prt_pkg::CNT_W'(1)),
    .count   (tot_cnt),
    .reached ()
  );

  // ==========================================================
  // sequencing
  // the wait line is looked at once, a fixed time into the strobe;
  // a device that has let it go high again by then adds no wait
  wire at_sample = ph_cnt == prt_pkg::CNT_W'(prt_pkg::TA_CYC);
  wire go_wait   = at_sample & use_iordy_reg & ~bus.iordy;
  wire setup_ok  = ph_cnt >= t1_cyc;
  wire pulse_ok  = ph_cnt >= t2_cyc;
  wire hold_ok   = ph_cnt >= t9_cyc;
  // recovery ends only once both its own minimum and the cycle
  // minimum are met, so the negated phase absorbs any shortfall
  wire recov_ok  = (ph_cnt >= t2i_cyc) & (tot_cnt >= t0_cyc);
  // read data is taken one edge after the strobe negates: the device
  // drives from its sampled strobe, so with the one-cycle strobe of
  // the fast modes the bus only holds valid data from then on
  wire rd_take = (state_reg == prt_pkg::H_HOLD)
               & (ph_cnt == prt_pkg::CNT_W'(1)) & ~wr_reg;

  always_comb begin
    state_next = state_reg;
    ph_clr     = 1'b0;
    tot_clr    = 1'b0;
    unique case (state_reg)
      prt_pkg::H_IDLE: begin
        if (req) begin
          state_next = prt_pkg::H_SETUP;
          ph_clr     = 1'b1;
        end
      end
      prt_pkg::H_SETUP: begin
        if (setup_ok) begin
          state_next = prt_pkg::H_STROBE;
          ph_clr     = 1'b1;
          tot_clr    = 1'b1;
        end
      end
      prt_pkg::H_STROBE: begin
        if (go_wait) begin
          state_next = prt_pkg::H_WAIT;
        end else if (pulse_ok) begin
          state_next = prt_pkg::H_HOLD;
          ph_clr     = 1'b1;
        end
      end
      prt_pkg::H_WAIT: begin
        // phase count keeps running so the pulse minimum still holds
        if (bus.iordy) begin
          state_next = prt_pkg::H_STROBE;
        end
      end
      prt_pkg::H_HOLD: begin
        if (hold_ok) begin
          state_next = prt_pkg::H_RECOV;
        end
      end
      prt_pkg::H_RECOV: begin
        if (recov_ok) begin
          state_next = prt_pkg::H_IDLE;
        end
      end
    endcase
  end

  wire take    = (state_reg == prt_pkg::H_IDLE) & req;
  wire strobe_on = state_next == prt_pkg::H_STROBE
                 | state_next == prt_pkg::H_WAIT;
  wire addr_on = state_next != prt_pkg::H_IDLE
               & state_next != prt_pkg::H_RECOV;

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg     <= prt_pkg::H_IDLE;
      wr_reg        <= 1'b0;
      cs_sel_reg    <= 1'b0;
      da_reg        <= 3'h0;
      wdata_reg     <= 8'h00;
      mode_reg      <= prt_pkg::PWRUP_MODE;
      use_iordy_reg <= 1'b0;
      cs0_n_reg     <= 1'b1;
      cs1_n_reg     <= 1'b1;
      dior_n_reg    <= 1'b1;
      diow_n_reg    <= 1'b1;
      dd_oe_reg     <= 1'b0;
      dmack_n_reg   <= 1'b1;
      busy          <= 1'b0;
      done          <= 1'b0;
      rdata         <= 8'h00;
      mode_used     <= prt_pkg::PWRUP_MODE;
      waited        <= 1'b0;
    end else begin
      state_reg   <= state_next;
      dmack_n_reg <= 1'b1;
      done        <= (state_reg == prt_pkg::H_RECOV) & recov_ok;
      busy        <= state_next != prt_pkg::H_IDLE;
      if (take) begin
        wr_reg        <= req_wr;
        cs_sel_reg    <= req_cs_sel;
        da_reg        <= req_da;
        wdata_reg     <= req_wdata;
        mode_reg      <= mode_next;
        mode_used     <= mode_next;
        use_iordy_reg <= iordy_always
                       | (mode_next >= prt_pkg::IORDY_MODE);
        waited        <= 1'b0;
      end
      if (state_reg == prt_pkg::H_WAIT) begin
        waited <= 1'b1;
      end
      cs0_n_reg  <= ~(addr_on & ~(take ? req_cs_sel : cs_sel_reg));
      cs1_n_reg  <= ~(addr_on & (take ? req_cs_sel : cs_sel_reg));
      dior_n_reg <= ~(strobe_on & ~wr_reg);
      diow_n_reg <= ~(strobe_on & wr_reg);
      dd_oe_reg  <= addr_on & (take ? req_wr : wr_reg);
      if (rd_take) begin
        rdata <= bus.dd;
      end
    end
  end

  assign bus.cs0_n    = cs0_n_reg;
  assign bus.cs1_n    = cs1_n_reg;
  assign bus.da       = da_reg;
  assign bus.dior_n   = dior_n_reg;
  assign bus.diow_n   = diow_n_reg;
  assign bus.dmack_n  = dmack_n_reg;
  assign bus.dd_h_out = wdata_reg;
  assign bus.dd_h_oe  = dd_oe_reg;
endmodule

// [logic/prt_timer.sv]
`timescale 1ns/1ps
module prt_timer #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         clr,
  input  wire logic [W-1:0] limit,
  output logic      [W-1:0] count,
  output logic              reached
);
  initial begin
    if (W < 2) $error("prt_timer: width too small");
  end

  // count holds the cycles spent since clr, the current one included;
  // it saturates so a long wait never wraps into a false early end
  logic [W-1:0] count_next;
  wire          at_top = &count;

  assign count_next = clr ? W'(1) : (at_top ? count : count + W'(1));
  assign reached    = count >= limit;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count <= W'(1);
    end else begin
      count <= count_next;
    end
  end
endmodule

// [testbench/pio_register_transfer_tb.sv]
`timescale 1ns/1ps
module pio_register_transfer_tb;
  logic        clk_sys, rst, req, req_wr, req_cs_sel, dev1_present;
  logic        ready, mode_wr, busy, done, waited, acc_cs_sel;
  logic        wr_pulse, mode_reject, wait_timeout, strb_q, sel_seen;
  logic        rej_seen, to_seen, rd_pulse;
  logic [2:0]  req_da, mode_req, dev0_mode, dev1_mode, mode_wr_val;
  logic [2:0]  acc_da, mode_cur, mode_used, da_seen;
  logic [7:0]  req_wdata, rd_data, rdata, wr_data, wr_seen;
  logic [15:0] word68;
  int          lo_cnt, lo_len, cyc_cnt, cyc_len, tmo, rd_cnt;
  int          failures, total_checks;

  prt_if       bus_if ();
  wire logic   strb = bus_if.dior_n & bus_if.diow_n;

  prt_host u_prt_host (.clk_sys(clk_sys), .rst(rst),
    .bus(bus_if.host_mp), .req(req), .req_wr(req_wr),
    .req_cs_sel(req_cs_sel), .req_da(req_da), .req_wdata(req_wdata),
    .mode_req(mode_req), .dev0_mode(dev0_mode), .dev1_mode(dev1_mode),
    .dev1_present(dev1_present), .iordy_always(1'b0), .busy(busy),
    .done(done), .rdata(rdata), .mode_used(mode_used), .waited(waited));
  prt_device #(.MAX_MODE(4), .CYCLE_NS(120)) u_prt_device (
    .clk_sys(clk_sys), .rst(rst), .bus(bus_if.dev_mp), .mode_wr(mode_wr),
    .mode_wr_val(mode_wr_val), .rd_data(rd_data), .ready(ready),
    .acc_cs_sel(acc_cs_sel), .acc_da(acc_da), .wr_pulse(wr_pulse),
    .wr_data(wr_data), .rd_pulse(rd_pulse), .mode_cur(mode_cur),
    .word68(word68),
    .mode_reject(mode_reject), .wait_timeout(wait_timeout));
  prt_asserts u_prt_asserts (.clk_sys(clk_sys), .rst(rst),
    .cs0_n(bus_if.cs0_n), .cs1_n(bus_if.cs1_n), .da(bus_if.da),
    .dior_n(bus_if.dior_n), .diow_n(bus_if.diow_n),
    .dmack_n(bus_if.dmack_n), .dd(bus_if.dd), .iordy(bus_if.iordy),
    .dd_h_oe(bus_if.dd_h_oe), .dd_d_oe(bus_if.dd_d_oe));

  // ==========================================================
  // clock, watchdog and wire monitor
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    tmo++;
    if (tmo == 3000) begin
      failures++;
      final_report();
    end
  end

  // strobe width and strobe-to-done span, in whole clock cycles
  always @(posedge clk_sys) begin
    if (!strb) begin
      lo_cnt <= lo_cnt + 1;
    end else if (lo_cnt != 0) begin
      lo_len <= lo_cnt;
      lo_cnt <= 0;
    end
    cyc_cnt <= (!strb && strb_q) ? 1 : cyc_cnt + 1;
    if (done) begin
      cyc_len <= cyc_cnt;
    end
    strb_q <= strb;
    if (wr_pulse) begin
      wr_seen <= wr_data;
    end
    da_seen  <= acc_da;
    sel_seen <= acc_cs_sel;
    rej_seen <= rej_seen | mode_reject;
    to_seen  <= to_seen | wait_timeout;
    if (rd_pulse) begin
      rd_cnt <= rd_cnt + 1;
    end
  end

  // ==========================================================
  // tasks
  function automatic int cyc(input int ns);
    return (ns + 99) / 100;
  endfunction

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic set_mode(input logic [2:0] v);
    @(posedge clk_sys); #1;
    mode_wr = 1'b1;
    mode_wr_val = v;
    @(posedge clk_sys); #1;
    mode_wr = 1'b0;
    @(posedge clk_sys); #1;
  endtask

  // one register cycle; req held until taken, then wait for done
  task automatic xfer(input logic wr, input logic sel,
                      input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys); #1;
    req = 1'b1;
    req_wr = wr;
    req_cs_sel = sel;
    req_da = a;
    req_wdata = d;
    while (busy !== 1'b1 && n < 20) begin
      @(posedge clk_sys); #1;
      n++;
    end
    req = 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk_sys); #1;
      n++;
    end
    check("done_seen", 16'(done), 16'h1);
    @(posedge clk_sys); #1;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {req, req_wr, req_cs_sel, dev1_present, mode_wr} = 5'h0;
    {req_da, mode_req, mode_wr_val, dev1_mode} = 12'h0;
    {req_wdata, rd_data} = 16'h0;
    {rej_seen, to_seen} = 2'h0;
    dev0_mode = 3'h4;
    ready = 1'b1;
    rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1 rst = 1'b0;
    @(posedge clk_sys); #1;
    check("mode_cur", 16'(mode_cur), 16'h0);
    check("word68", word68, 16'h78);
    check("word68_min",
          16'(word68 >= 16'(prt_pkg::T0_NS[4])), 16'h1);
    check("mode_used", 16'(mode_used), 16'h0);
    $display("test reset done");

    for (int m = 0; m < 5; m++) begin
      set_mode(3'(m));
      check("mode_cur", 16'(mode_cur), 16'(m));
      mode_req = 3'(m);
      xfer(1'b1, 1'(m), 3'(m), 8'hA0 + 8'(m));
      check("wr_data", 16'(wr_seen), 16'hA0 + 16'(m));
      check("acc_da", 16'(da_seen), 16'(m));
      check("acc_sel", 16'(sel_seen), 16'(m % 2));
      check("mode_used", 16'(mode_used), 16'(m));
      check("t2", 16'(lo_len >= cyc(prt_pkg::T2_NS[m])), 16'h1);
      check("t0", 16'(cyc_len >= cyc(prt_pkg::T0_NS[m])), 16'h1);
      check("waited", 16'(waited), 16'h0);
      rd_data = 8'h5A ^ 8'(m);
      xfer(1'b0, 1'(m + 1), 3'(7 - m), 8'h00);
      check("rdata", 16'(rdata), 16'h5A ^ 16'(m));
      check("acc_da", 16'(da_seen), 16'(7 - m));
      check("t2", 16'(lo_len >= cyc(prt_pkg::T2_NS[m])), 16'h1);
    end
    check("rd_pulse", 16'(rd_cnt), 16'h5);
    $display("test modes done");

    set_mode(3'h3);
    mode_req = 3'h3;
    ready = 1'b0;
    fork
      xfer(1'b0, 1'b0, 3'h2, 8'h00);
      begin
        repeat (6) @(posedge clk_sys);
        #1 rd_data = 8'hC3;
        ready = 1'b1;
      end
    join
    check("rdata", 16'(rdata), 16'hC3);
    check("waited", 16'(waited), 16'h1);
    check("rd_pulse", 16'(rd_cnt), 16'h6);
    $display("test wait done");

    set_mode(3'h4);
    mode_req = 3'h4;
    ready = 1'b0;
    xfer(1'b1, 1'b1, 3'h6, 8'h3C);
    ready = 1'b1;
    check("timeout", 16'(to_seen), 16'h1);
    check("wr_data", 16'(wr_seen), 16'h3C);
    $display("test timeout done");

    set_mode(3'h5);
    check("reject", 16'(rej_seen), 16'h1);
    check("mode_cur", 16'(mode_cur), 16'h4);
    $display("test reject done");

    dev1_present = 1'b1;
    dev1_mode = 3'h1;
    xfer(1'b1, 1'b0, 3'h1, 8'h11);
    check("mode_used", 16'(mode_used), 16'h1);
    check("t2", 16'(lo_len >= cyc(prt_pkg::T2_NS[1])), 16'h1);
    dev1_present = 1'b0;
    dev0_mode = 3'h2;
    xfer(1'b1, 1'b0, 3'h1, 8'h22);
    check("mode_used", 16'(mode_used), 16'h2);
    dev0_mode = 3'h4;
    xfer(1'b1, 1'b0, 3'h1, 8'h33);
    check("mode_used", 16'(mode_used), 16'h4);
    $display("test two devices done");
    final_report();
  end
endmodule

// [testbench/prt_asserts.sv]
`timescale 1ns/1ps
module prt_asserts (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       cs0_n,
  input wire logic       cs1_n,
  input wire logic [2:0] da,
  input wire logic       dior_n,
  input wire logic       diow_n,
  input wire logic       dmack_n,
  input wire logic [7:0] dd,
  input wire logic       iordy,
  input wire logic       dd_h_oe,
  input wire logic       dd_d_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==========================================================
  // helpers
  wire logic strb_lo = !dior_n || !diow_n;
  logic [4:0] wait_cnt;

  // a device that never lets go would hang the host forever
  always_ff @(posedge clk_sys) begin
    if (rst || !(strb_lo && !iordy)) begin
      wait_cnt <= 5'h0;
    end else begin
      wait_cnt <= wait_cnt + 5'h1;
    end
  end

  sequence strobe_fall;
    $fell(dior_n) || $fell(diow_n);
  endsequence

  sequence strobe_rise;
    $rose(dior_n) || $rose(diow_n);
  endsequence

  // ==========================================================
  // assertions
  chk_dmack_idle: assert property (dmack_n)
    else $error("dma acknowledge asserted");
  chk_one_strobe: assert property (!(!dior_n && !diow_n))
    else $error("both strobes low");
  chk_addr_setup: assert property (strobe_fall |->
    $past(cs0_n ^ cs1_n) && $stable(da))
    else $error("address not set up before strobe");
  chk_addr_hold: assert property (strobe_rise |->
    $stable(da) && (cs0_n ^ cs1_n))
    else $error("address not held after strobe");
  chk_wait_holds: assert property (strb_lo && !iordy |=> strb_lo)
    else $error("strobe ended while wait line low");
  chk_wait_bound: assert property (wait_cnt <= 5'hD)
    else $error("wait line held low too long");
  // data must already stand a cycle before the release, not arrive with it
  chk_read_first: assert property ($rose(iordy) && !dior_n |->
    dd_d_oe && !dd_h_oe && $stable(dd))
    else $error("wait released before read data driven");
  chk_wait_ends: assert property ($rose(iordy) && strb_lo |->
    ##[0:4] !strb_lo)
    else $error("cycle not completed after wait");
  chk_write_drive: assert property (!diow_n |-> dd_h_oe && !dd_d_oe)
    else $error("write data not driven by host");
  chk_recovery_min: assert property (strobe_rise |=> !strb_lo)
    else $error("no recovery between strobes");
endmodule
